// ### verilog/tmr_pkg.sv
// Constants and types for the down timer with PWM and buzzer
// Function
// - Reading the count register returns the live 8-bit down-counter value.
// - Writing the count register loads reload value and counter together.
// - Continuous, no auto reload: count to 0x00, underflow restarts at 0xFF.
// - Continuous with auto reload: underflow reloads the stored reload value.
// - One-shot: count once down to 0x00 and stop at underflow.
// - Each underflow sets a sticky flag until software clears it.
// - Polarity bit set makes PWM active low, clear makes it active high.
// - PWM enable drives the shared pin with PWM, else buzzer enable drives it with the buzzer, else pin is GPIO.
// - PWM inactive after start, active from count equal duty until underflow.
// - Reload value sets PWM period, duty value sets active part.
// - Duty register is write-only and reads back as zero.
// - Prescaler field divides count clock by 2^(field+1), 1:2 to 1:256.
// - Edge bit set counts falling external edges, clear counts rising edges.
// - Source bit selects external pin when set, instruction clock when clear.
// - Reading the prescaler count register returns the live prescaler value.
// - Buzzer codes 0-7 give prescaler output divided by 2^(code+1).
// - Buzzer codes 8-15 follow timer count bit 0 to 7.
// - Buzzer enable bit turns buzzer output on or off.
package tmr_pkg;

  localparam int          ADDR_W       = 12;
  localparam logic [2:0]  IDX_COUNT    = 3'h0;
  localparam logic [2:0]  IDX_TPC      = 3'h1;
  localparam logic [2:0]  IDX_CLK      = 3'h2;
  localparam logic [2:0]  IDX_DUTY     = 3'h3;
  localparam logic [2:0]  IDX_PSC      = 3'h4;
  localparam logic [2:0]  IDX_BZ       = 3'h5;
  localparam logic [2:0]  IDX_FLAG     = 3'h6;

  localparam int          TPC_EN       = 0;
  localparam int          TPC_RL       = 1;
  localparam int          TPC_OS       = 2;
  localparam int          TPC_AL       = 6;
  localparam int          TPC_OEN      = 7;
  localparam logic [7:0]  TPC_WMASK    = 8'hC7;
  localparam logic [7:0]  TPC_RMASK    = 8'h07;
  localparam logic [7:0]  TPC_RST      = 8'h00;

  localparam int          CLK_PS_LSB   = 0;
  localparam int          CLK_PSDIS    = 3;
  localparam int          CLK_CE       = 4;
  localparam int          CLK_CS       = 5;
  localparam logic [7:0]  CLK_WMASK    = 8'h3F;
  localparam logic [7:0]  CLK_RST      = 8'h3F;

  localparam int          BZ_FS_LSB    = 0;
  localparam int          BZ_EN        = 7;
  localparam logic [7:0]  BZ_WMASK     = 8'h8F;
  localparam logic [7:0]  BZ_RST       = 8'h0F;

  localparam int          FLAG_UF      = 0;
  localparam logic [7:0]  COUNT_RST    = 8'h00;
  localparam logic [7:0]  RELOAD_RST   = 8'h00;
  localparam logic [7:0]  DUTY_RST     = 8'h00;
  localparam logic [7:0]  PSC_RST      = 8'hFF;
  localparam logic [7:0]  WRAP_VAL     = 8'hFF;
  localparam logic [7:0]  ZERO_VAL     = 8'h00;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [3:0]        pstrb;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic out;
    logic oe;
  } pin_t;

  typedef enum logic [1:0] {
    TM_IDLE = 2'b00,
    TM_RUN  = 2'b01,
    TM_DONE = 2'b10
  } tm_state_t;

endpackage

// ### verilog/down_timer_pwm_buzzer.sv
// Down timer with prescaler, PWM and buzzer on a shared pin, APB slave
//
// The APB register port was chosen for this implementation.
module down_timer_pwm_buzzer (
  input  wire logic              CORE_CLK,
  input  wire logic              NRST,
  input  tmr_pkg::apb_req_t      APB_REQ,
  output tmr_pkg::apb_rsp_t      APB_RSP,
  input  wire logic              EXT_CLK_PIN,
  input  wire logic              GPIO_OUT,
  input  wire logic              GPIO_OE,
  output tmr_pkg::pin_t          PIN
);
  import tmr_pkg::*;

  function automatic logic reg_ok(input logic [ADDR_W-1:0] a);
    reg_ok = (a[ADDR_W-1:5] == '0) && (a[1:0] == 2'h0) && (a[4:2] <= IDX_FLAG);
  endfunction

  function automatic logic [2:0] reg_idx(input logic [ADDR_W-1:0] a);
    reg_idx = a[4:2];
  endfunction

  function automatic logic [7:0] div_mask(input logic [2:0] rate);
    div_mask = 8'(({1'b0, 8'hFF} >> (3'h7 - rate)));
  endfunction

  logic [1:0]  ext_sync_r;
  logic        ext_prev_r;
  logic [7:0]  cnt_r;
  logic [7:0]  cnt_nxt;
  logic [7:0]  reload_r;
  logic [7:0]  tpc_r;
  logic [7:0]  clk_r;
  logic [7:0]  duty_r;
  logic [7:0]  bz_r;
  logic [7:0]  psc_r;
  logic [7:0]  psc_nxt;
  logic [7:0]  bz_cnt_r;
  logic        flag_r;
  logic        pwm_act_r;
  logic        pwm_act_nxt;
  logic [31:0] prdata_r;
  logic        slverr_r;
  logic [7:0]  rd_val;
  pin_t        pin_r;
  pin_t        pin_nxt;
  tm_state_t   state_r;
  tm_state_t   state_nxt;

  logic        setup;
  logic        wr_en;
  logic [2:0]  idx;
  logic        wr_count;
  logic        flag_clr;
  logic        ext_rise;
  logic        ext_fall;
  logic        src_tick;
  logic        psc_tick;
  logic        pre_tick;
  logic        run;
  logic        step;
  logic        uflow;
  logic        pwm_level;
  logic        bz_src;
  logic        bz_level;

  // Pin is asynchronous to the core; only the second stage is used
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      ext_sync_r <= 2'b00;
      ext_prev_r <= 1'b0;
    end else begin
      ext_sync_r <= {ext_sync_r[0], EXT_CLK_PIN};
      ext_prev_r <= ext_sync_r[1];
    end
  end

  assign ext_rise = ext_sync_r[1] & ~ext_prev_r;
  assign ext_fall = ~ext_sync_r[1] & ext_prev_r;

  // Bus decode; zero wait states, writes land on the access edge
  assign setup = APB_REQ.psel & ~APB_REQ.penable;
  assign idx   = reg_idx(APB_REQ.paddr);
  assign wr_en = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite
               & APB_REQ.pstrb[0] & reg_ok(APB_REQ.paddr);
  assign wr_count = wr_en && (idx == IDX_COUNT);
  assign flag_clr = wr_en && (idx == IDX_FLAG) && APB_REQ.pwdata[FLAG_UF];

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      reload_r <= RELOAD_RST;
    end else if (wr_count) begin
      reload_r <= APB_REQ.pwdata[7:0];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      tpc_r <= TPC_RST;
    end else if (wr_en && (idx == IDX_TPC)) begin
      tpc_r <= APB_REQ.pwdata[7:0] & TPC_WMASK;
    end
  end

  // Rate changes while the prescaler runs may cause a false underflow
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      clk_r <= CLK_RST;
    end else if (wr_en && (idx == IDX_CLK)) begin
      clk_r <= APB_REQ.pwdata[7:0] & CLK_WMASK;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      duty_r <= DUTY_RST;
    end else if (wr_en && (idx == IDX_DUTY)) begin
      duty_r <= APB_REQ.pwdata[7:0];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      bz_r <= BZ_RST;
    end else if (wr_en && (idx == IDX_BZ)) begin
      bz_r <= APB_REQ.pwdata[7:0] & BZ_WMASK;
    end
  end

  always_comb begin
    rd_val = 8'h00;
    unique case (idx)
      IDX_COUNT: rd_val = cnt_r;
      IDX_TPC:   rd_val = tpc_r & TPC_RMASK;
      IDX_CLK:   rd_val = clk_r;
      IDX_DUTY:  rd_val = 8'h00;
      IDX_PSC:   rd_val = psc_r;
      IDX_BZ:    rd_val = 8'h00;
      IDX_FLAG:  rd_val = {7'h00, flag_r};
      default:   rd_val = 8'h00;
    endcase
  end

  // Read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      prdata_r <= 32'h00000000;
      slverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= (reg_ok(APB_REQ.paddr) && !APB_REQ.pwrite) ? {24'h000000, rd_val} : 32'h0;
      slverr_r <= ~reg_ok(APB_REQ.paddr);
    end
  end

  always_comb begin
    APB_RSP.prdata  = prdata_r;
    APB_RSP.pready  = 1'b1;
    APB_RSP.pslverr = slverr_r & APB_REQ.psel & APB_REQ.penable;
  end

  // Count source: every core cycle is one instruction clock
  always_comb begin
    if (clk_r[CLK_CS]) begin
      src_tick = clk_r[CLK_CE] ? ext_fall : ext_rise;
    end else begin
      src_tick = 1'b1;
    end
  end

  assign run      = (state_r == TM_RUN);
  assign psc_nxt  = psc_r - 8'h01;
  assign psc_tick = src_tick
                  && ((psc_nxt & div_mask(clk_r[CLK_PS_LSB +: 3])) == 8'h00);
  assign pre_tick = run & (clk_r[CLK_PSDIS] ? src_tick : psc_tick);
  assign step     = pre_tick;
  assign uflow    = step && (cnt_r == ZERO_VAL);

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      psc_r <= PSC_RST;
    end else if (state_r == TM_IDLE) begin
      psc_r <= PSC_RST;
    end else if (run && !clk_r[CLK_PSDIS] && src_tick) begin
      psc_r <= psc_nxt;
    end
  end

  always_comb begin
    cnt_nxt = cnt_r;
    if (wr_count) begin
      cnt_nxt = APB_REQ.pwdata[7:0];
    end else if (step) begin
      if (cnt_r != ZERO_VAL) begin
        cnt_nxt = cnt_r - 8'h01;
      end else if (tpc_r[TPC_OS]) begin
        cnt_nxt = ZERO_VAL;
      end else if (tpc_r[TPC_RL]) begin
        cnt_nxt = reload_r;
      end else begin
        cnt_nxt = WRAP_VAL;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      cnt_r <= COUNT_RST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      TM_IDLE: begin
        if (tpc_r[TPC_EN]) begin
          state_nxt = TM_RUN;
        end
      end
      TM_RUN: begin
        if (!tpc_r[TPC_EN]) begin
          state_nxt = TM_IDLE;
        end else if (uflow && tpc_r[TPC_OS] && !wr_count) begin
          state_nxt = TM_DONE;
        end
      end
      TM_DONE: begin
        if (!tpc_r[TPC_EN]) begin
          state_nxt = TM_IDLE;
        end else if (wr_count) begin
          state_nxt = TM_RUN;
        end
      end
      default: state_nxt = TM_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      state_r <= TM_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // A new underflow in the clearing cycle keeps the flag set
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      flag_r <= 1'b0;
    end else if (uflow) begin
      flag_r <= 1'b1;
    end else if (flag_clr) begin
      flag_r <= 1'b0;
    end
  end

  always_comb begin
    pwm_act_nxt = pwm_act_r;
    if (state_r == TM_IDLE) begin
      pwm_act_nxt = 1'b0;
    end else if (step) begin
      if (uflow) begin
        pwm_act_nxt = 1'b0;
      end else if (cnt_nxt == duty_r) begin
        pwm_act_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      pwm_act_r <= 1'b0;
    end else begin
      pwm_act_r <= pwm_act_nxt;
    end
  end

  assign pwm_level = pwm_act_r ^ tpc_r[TPC_AL];

  // Buzzer divider runs on the prescaler output
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      bz_cnt_r <= 8'h00;
    end else if (state_r == TM_IDLE) begin
      bz_cnt_r <= 8'h00;
    end else if (pre_tick) begin
      bz_cnt_r <= bz_cnt_r + 8'h01;
    end
  end

  always_comb begin
    if (bz_r[BZ_FS_LSB + 3]) begin
      bz_src = cnt_r[bz_r[BZ_FS_LSB +: 3]];
    end else begin
      bz_src = bz_cnt_r[bz_r[BZ_FS_LSB +: 3]];
    end
  end

  assign bz_level = bz_r[BZ_EN] & bz_src;

  // PWM takes the pin before the buzzer when both are enabled
  always_comb begin
    if (tpc_r[TPC_OEN]) begin
      pin_nxt.out = pwm_level;
      pin_nxt.oe  = 1'b1;
    end else if (bz_r[BZ_EN]) begin
      pin_nxt.out = bz_level;
      pin_nxt.oe  = 1'b1;
    end else begin
      pin_nxt.out = GPIO_OUT;
      pin_nxt.oe  = GPIO_OE;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      pin_r <= '0;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  assign PIN = pin_r;

endmodule

// ### verification/tmr_asserts.sv
// Port assertions for the down timer with PWM and buzzer
module tmr_asserts (
  input wire logic         CORE_CLK,
  input wire logic         NRST,
  input tmr_pkg::apb_req_t APB_REQ,
  input tmr_pkg::apb_rsp_t APB_RSP,
  input wire logic         EXT_CLK_PIN,
  input wire logic         GPIO_OUT,
  input wire logic         GPIO_OE,
  input tmr_pkg::pin_t     PIN
);
  timeunit 1ns;
  timeprecision 1ps;
  import tmr_pkg::*;
  logic acc;
  logic rd;
  logic wr_seen_r;
  assign acc = APB_REQ.psel && APB_REQ.penable;
  assign rd  = acc && !APB_REQ.pwrite;
  // Until the first write all settings still hold reset values
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) wr_seen_r <= 1'h0;
    else if (acc && APB_REQ.pwrite) wr_seen_r <= 1'h1;
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  a_ready_high: assert property (
    APB_RSP.pready) else $error("pready low");
  a_unmapped_err: assert property (
    acc && APB_REQ.paddr == 12'h01C |-> APB_RSP.pslverr) else $error("no error on hole");
  a_mapped_ok: assert property (
    acc && APB_REQ.paddr == 12'h000 |-> !APB_RSP.pslverr) else $error("error on count");
  a_duty_zero: assert property (
    rd && APB_REQ.paddr == 12'h00C |-> APB_RSP.prdata == 32'h0) else $error("duty readable");
  a_buzz_zero: assert property (
    rd && APB_REQ.paddr == 12'h014 |-> APB_RSP.prdata == 32'h0) else $error("buzzer readable");
  a_count_reset: assert property (
    rd && !wr_seen_r && APB_REQ.paddr == 12'h000 |-> APB_RSP.prdata == 32'h0)
    else $error("count not zero");
  a_presc_full: assert property (
    rd && !wr_seen_r && $past(NRST) && APB_REQ.paddr == 12'h010
    |-> APB_RSP.prdata == {24'h0, PSC_RST}) else $error("prescaler not full");
  a_pin_gpio: assert property (
    NRST && !wr_seen_r && !(acc && APB_REQ.pwrite)
    |=> PIN.out == $past(GPIO_OUT) && PIN.oe == $past(GPIO_OE)) else $error("pin not gpio");
endmodule
bind down_timer_pwm_buzzer tmr_asserts u_asserts (.CORE_CLK(CORE_CLK), .NRST(NRST),
  .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .EXT_CLK_PIN(EXT_CLK_PIN), .GPIO_OUT(GPIO_OUT),
  .GPIO_OE(GPIO_OE), .PIN(PIN));

// ### verification/ext_count_source.sv
// External count pin source: bursts of toggles, still between bursts
module ext_count_source (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       go,
  input  wire logic [7:0] toggles,
  output logic            pin,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_r;
  logic [1:0] ph_r;
  // Four cycles per level, slow enough for the synchroniser
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      left_r <= 8'h00;
      ph_r <= 2'h0;
      pin <= 1'h0;
    end else if (go && left_r == 8'h00) begin
      left_r <= toggles;
    end else if (left_r != 8'h00) begin
      ph_r <= ph_r + 2'h1;
      if (ph_r == 2'h3) begin
        pin <= ~pin;
        left_r <= left_r - 8'h01;
      end
    end
  end
  assign busy = (left_r != 8'h00);
endmodule

// ### verification/down_timer_pwm_buzzer_tb_top.sv
// Register-level tests for the down timer with PWM and buzzer
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("[FAIL] %s expected %0h seen %0h", what, exp, got); end end
module down_timer_pwm_buzzer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tmr_pkg::*;
  logic        clk = 1'h0;
  logic        nrst = 1'h0;
  apb_req_t    req = '0;
  apb_rsp_t    rsp;
  pin_t        pin;
  logic        gpio_out = 1'h1;
  logic        gpio_oe = 1'h1;
  logic        go = 1'h0;
  logic        ext_pin;
  logic        ext_busy;
  logic        err;
  logic [31:0] rdata;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          t0;
  int          t1;
  int          hi;
  int          tg;
  logic [11:0] ra [7] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018};
  logic [31:0] rv [7] = '{32'h00, 32'h00, 32'h3F, 32'h00, 32'hFF, 32'h00, 32'h00};
  logic [7:0]  mode [3] = '{8'h01, 8'h03, 8'h05};
  logic [31:0] uf [3] = '{32'hFF, 32'h03, 32'h00};
  logic [3:0]  bz [5] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9};
  int          bzt [5] = '{200, 100, 50, 200, 100};

  always #2.5 clk = ~clk;
  always @(posedge clk) cyc++;

  down_timer_pwm_buzzer dut (.CORE_CLK(clk), .NRST(nrst), .APB_REQ(req), .APB_RSP(rsp),
    .EXT_CLK_PIN(ext_pin), .GPIO_OUT(gpio_out), .GPIO_OE(gpio_oe), .PIN(pin));
  ext_count_source u_ext (.clk(clk), .rst_n(nrst), .go(go), .toggles(8'h09), .pin(ext_pin),
    .busy(ext_busy));

  task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: a, pwdata: {24'h0, d}, pstrb: 4'hF};
    @(posedge clk);
    req.penable <= 1'h1;
    do @(posedge clk); while (rsp.pready !== 1'h1);
    rdata = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'h0;
    req.penable <= 1'h0;
  endtask

  task automatic wait_flag();
    rdata = '0;
    while (rdata[0] !== 1'h1) bus(1'h0, 12'h018, 8'h00);
  endtask

  // Counts high cycles and edges of the pin over 400 cycles
  task automatic watch();
    logic last;
    hi = 0;
    tg = 0;
    last = pin.out;
    repeat (400) begin
      @(posedge clk);
      hi += (pin.out === 1'h1);
      tg += (pin.out !== last);
      last = pin.out;
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    complete_run();
  end

  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'h1;
    for (int i = 0; i < 7; i++) begin
      bus(1'h0, ra[i], 8'h00);
      `CHK("reset read", rv[i], rdata)
    end
    bus(1'h0, 12'h01C, 8'h00);
    `CHK("hole error", 1'h1, err)
    `CHK("pin gpio", 2'h3, pin)
    bus(1'h1, 12'h00C, 8'h5A);
    bus(1'h0, 12'h00C, 8'h00);
    `CHK("duty write-only", 32'h0, rdata)
    $display("test reset done");
    // Rate only changes with the prescaler bypassed
    bus(1'h1, 12'h008, 8'h0F);
    bus(1'h1, 12'h008, 8'h07);
    for (int m = 0; m < 3; m++) begin
      bus(1'h1, 12'h004, 8'h00);
      bus(1'h1, 12'h018, 8'h01);
      bus(1'h1, 12'h000, 8'h03);
      bus(1'h1, 12'h004, mode[m]);
      t0 = cyc;
      wait_flag();
      t1 = cyc;
      `CHK("four steps at 1:256", 1'h1, t1 - t0 > 1000 && t1 - t0 < 1040)
      bus(1'h0, 12'h000, 8'h00);
      `CHK("count after underflow", uf[m], rdata)
    end
    repeat (600) @(posedge clk);
    bus(1'h0, 12'h000, 8'h00);
    `CHK("one-shot stays", 32'h0, rdata)
    bus(1'h0, 12'h018, 8'h00);
    `CHK("flag sticky", 32'h1, rdata)
    bus(1'h1, 12'h018, 8'h01);
    bus(1'h0, 12'h018, 8'h00);
    `CHK("flag cleared", 32'h0, rdata)
    $display("test count modes done");
    bus(1'h1, 12'h008, 8'h0F);
    bus(1'h1, 12'h00C, 8'h00);
    for (int p = 0; p < 2; p++) begin
      bus(1'h1, 12'h004, 8'h00);
      bus(1'h1, 12'h000, 8'h03);
      bus(1'h1, 12'h004, p ? 8'hC3 : 8'h83);
      watch();
      t0 = p ? 300 : 100;
      `CHK("pwm high cycles", 1'h1, hi >= t0 - 2 && hi <= t0 + 2)
      `CHK("pwm owns pin", 1'h1, pin.oe)
    end
    $display("test pwm done");
    bus(1'h1, 12'h004, 8'h03);
    bus(1'h1, 12'h008, 8'h08);
    bus(1'h1, 12'h008, 8'h00);
    for (int b = 0; b < 5; b++) begin
      bus(1'h1, 12'h014, {4'h8, bz[b]});
      watch();
      `CHK("buzzer edges", 1'h1, tg >= bzt[b] - 2 && tg <= bzt[b] + 2)
    end
    gpio_oe <= 1'h0;
    bus(1'h1, 12'h014, 8'h08);
    repeat (2) @(posedge clk);
    `CHK("buzzer off", 2'h2, pin)
    $display("test buzzer done");
    for (int e = 0; e < 2; e++) begin
      bus(1'h1, 12'h004, 8'h00);
      bus(1'h1, 12'h008, e ? 8'h38 : 8'h28);
      bus(1'h1, 12'h000, 8'h10);
      bus(1'h1, 12'h004, 8'h01);
      repeat (20) @(posedge clk);
      bus(1'h0, 12'h000, 8'h00);
      `CHK("ext source idle", 32'h10, rdata)
      go <= 1'h1;
      @(posedge clk);
      go <= 1'h0;
      @(posedge clk);
      while (ext_busy === 1'h1) @(posedge clk);
      repeat (5) @(posedge clk);
      bus(1'h0, 12'h000, 8'h00);
      `CHK("ext edges counted", 32'h0B, rdata)
    end
    $display("test external clock done");
    complete_run();
  end
endmodule
